/* File: rtl/capture_compare_unit.sv */
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module capture_compare_unit
	import capture_compare_pkg::*;
(
	input  wire logic                               hclk,
	input  wire logic                               hresetn,
	input  wire logic                               hsel,
	input  wire logic [31:0]                        haddr,
	input  wire logic [1:0]                         htrans,
	input  wire logic                               hwrite,
	input  wire logic [2:0]                         hsize,
	input  wire logic [31:0]                        hwdata,
	input  wire logic                               hready,
	output logic                                    hreadyout,
	output logic                                    hresp,
	output logic [31:0]                             hrdata,
	output logic                                    irq,
	input  wire logic                               time_base_a_count_pin,
	input  wire logic [capture_compare_pkg::NUM_CHANNELS-1:0] chan_pin_in,
	output logic [capture_compare_pkg::NUM_CHANNELS-1:0]      chan_pin_out,
	output logic [capture_compare_pkg::NUM_CHANNELS-1:0]      chan_pin_oe
);
	import capture_compare_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	bus_state_t              state;
	logic [11:0]             addr_q;
	logic                    accept;
	logic                    wr_en;
	logic [31:0]             rd_data;
	logic [CTL_W-1:0]        control;
	logic [15:0]             reload     [2];
	logic [15:0]             time_val   [2];
	logic [PRESC_W-1:0]      presc_cnt  [2];
	logic [PRESC_W-1:0]      presc_top  [2];
	logic [2:0]              presc_sel  [2];
	logic [1:0]              run;
	logic [1:0]              tick;
	logic [1:0]              upd;
	logic [1:0]              ovf;
	logic [1:0]              wr_timer;
	logic [1:0]              wr_reload;
	logic                    count_prev;
	logic                    count_edge;
	logic [STAT_W-1:0]       status;
	logic [STAT_W-1:0]       mask;
	logic [STAT_W-1:0]       stat_set;
	logic [NUM_PAIRS-1:0]    double_en;
	chan_cfg_t               chan_cfg   [NUM_CHANNELS];
	logic [15:0]             chan_value [NUM_CHANNELS];
	logic [NUM_CHANNELS-1:0] chan_event;
	logic [NUM_CHANNELS-1:0] chan_match;
	logic [NUM_CHANNELS-1:0] wr_value;
	logic [NUM_CHANNELS-1:0] wr_cfg;
	time_bus_t               tb;
	logic [3:0]              chan_idx;

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------

	// address phase accepted when selected, non-idle and bus ready
	assign accept   = hsel && htrans[1] && hready;
	assign wr_en    = (state == BUS_WRITE);
	assign chan_idx = addr_q[5:2];

	// data phase sequencing: writes finish at once, reads add one wait
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state     <= BUS_IDLE;
			addr_q    <= 12'h000;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
		end
		else if (accept)
		begin
			addr_q    <= haddr[11:0];
			state     <= hwrite ? BUS_WRITE : BUS_READ;
			hreadyout <= hwrite;
		end
		else
		begin
			case (state)
				BUS_READ:
				begin
					hrdata    <= rd_data;
					hreadyout <= 1'b1;
					state     <= BUS_IDLE;
				end
				BUS_WRITE:
					state <= BUS_IDLE;
				BUS_IDLE:
					state <= BUS_IDLE;
				default:
					state <= BUS_IDLE;
			endcase
		end
	end

	// response is always okay
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	// register read multiplexer, unmapped offsets read as zero
	always_comb
	begin
		rd_data = 32'h0000_0000;
		if (addr_q >= OFS_CHAN_VALUE && addr_q < OFS_CHAN_CFG)
		begin
			if (chan_idx < 4'(NUM_CHANNELS))
				rd_data[15:0] = chan_value[chan_idx];
		end
		else if (addr_q >= OFS_CHAN_CFG && addr_q < 12'h0C0)
		begin
			if (chan_idx < 4'(NUM_CHANNELS))
				rd_data[5:0] = chan_cfg[chan_idx];
		end
		else
		begin
			case (addr_q)
				OFS_CONTROL:   rd_data[CTL_W-1:0] = control;
				OFS_RELOAD_A:  rd_data[15:0] = reload[0];
				OFS_RELOAD_B:  rd_data[15:0] = reload[1];
				OFS_TIMER_A:   rd_data[15:0] = time_val[0];
				OFS_TIMER_B:   rd_data[15:0] = time_val[1];
				OFS_STATUS:    rd_data[STAT_W-1:0] = status;
				OFS_MASK:      rd_data[STAT_W-1:0] = mask;
				OFS_DOUBLE:    rd_data[NUM_PAIRS-1:0] = double_en;
				OFS_PIN_STATE: rd_data[NUM_CHANNELS-1:0] = chan_pin_out;
				default:       rd_data = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------

	// control, mask and double mode enables
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			control   <= '0;
			mask      <= '0;
			double_en <= '0;
		end
		else if (wr_en)
		begin
			if (addr_q == OFS_CONTROL)
				control <= hwdata[CTL_W-1:0];
			if (addr_q == OFS_MASK)
				mask <= hwdata[STAT_W-1:0];
			if (addr_q == OFS_DOUBLE)
				double_en <= hwdata[NUM_PAIRS-1:0];
		end
	end

	// channel configuration, one word per channel
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < NUM_CHANNELS; i++)
				chan_cfg[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_CHANNELS; i++)
				if (wr_cfg[i])
					chan_cfg[i] <= chan_cfg_t'(hwdata[5:0]);
		end
	end

	// per-channel and per-timer write strobes
	always_comb
	begin
		for (int i = 0; i < NUM_CHANNELS; i++)
		begin
			wr_value[i] = wr_en && (addr_q == OFS_CHAN_VALUE + 12'(4 * i));
			wr_cfg[i]   = wr_en && (addr_q == OFS_CHAN_CFG + 12'(4 * i));
		end
		wr_timer[0]  = wr_en && (addr_q == OFS_TIMER_A);
		wr_timer[1]  = wr_en && (addr_q == OFS_TIMER_B);
		wr_reload[0] = wr_en && (addr_q == OFS_RELOAD_A);
		wr_reload[1] = wr_en && (addr_q == OFS_RELOAD_B);
	end

	// ----------------------------------------------------------------
	// time bases
	// ----------------------------------------------------------------

	assign run[0]       = control[CTL_RUN_A];
	assign run[1]       = control[CTL_RUN_B];
	assign presc_sel[0] = control[CTL_PRESC_A +: 3];
	assign presc_sel[1] = control[CTL_PRESC_B +: 3];

	// rising edge on the external count pin
	assign count_edge = time_base_a_count_pin && !count_prev;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			count_prev <= 1'b0;
		else
			count_prev <= time_base_a_count_pin;
	end

	// prescaler period is the finest step times a power of two
	always_comb
	begin
		for (int t = 0; t < 2; t++)
			presc_top[t] = PRESC_W'((TICK_CYCLES << presc_sel[t]) - 1);
	end

	// tick source: external pulses for time base a when chosen
	always_comb
	begin
		tick[0] = run[0] && (control[CTL_EXT_A] ? count_edge
			: (presc_cnt[0] == presc_top[0]));
		tick[1] = run[1] && (presc_cnt[1] == presc_top[1]);
	end

	generate
		for (genvar t = 0; t < 2; t++)
		begin : g_time_base
			// prescaler counter
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					presc_cnt[t] <= '0;
				else if (!run[t] || presc_cnt[t] == presc_top[t])
					presc_cnt[t] <= '0;
				else
					presc_cnt[t] <= presc_cnt[t] + PRESC_W'(1);
			end

			// reload register
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					reload[t] <= RST_RELOAD;
				else if (wr_reload[t])
					reload[t] <= hwdata[15:0];
			end

			// up counter with reload on overflow; software write wins
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					time_val[t] <= RST_TIMER;
					upd[t]      <= 1'b0;
					ovf[t]      <= 1'b0;
				end
				else
				begin
					upd[t] <= tick[t] && !wr_timer[t];
					ovf[t] <= tick[t] && !wr_timer[t] && (time_val[t] == TIMER_TOP);
					if (wr_timer[t])
						time_val[t] <= hwdata[15:0];
					else if (tick[t] && time_val[t] == TIMER_TOP)
						time_val[t] <= reload[t];
					else if (tick[t])
						time_val[t] <= time_val[t] + 16'h0001;
				end
			end
		end
	endgenerate

	// shared view of both time bases for the channels
	assign tb = '{value_a: time_val[0], value_b: time_val[1], upd_a: upd[0],
		upd_b: upd[1], ovf_a: ovf[0], ovf_b: ovf[1]};

	// ----------------------------------------------------------------
	// channels
	// ----------------------------------------------------------------

	generate
		for (genvar c = 0; c < NUM_CHANNELS; c++)
		begin : g_channel
			localparam bit IS_LOWER = (c < NUM_PAIRS);
			localparam bit IS_UPPER = (c >= NUM_PAIRS) && (c < 2 * NUM_PAIRS);
			localparam int PAIR     = IS_LOWER ? c : (IS_UPPER ? c - NUM_PAIRS : 0);
			localparam int PARTNER  = IS_LOWER ? c + NUM_PAIRS : c;

			capture_compare_channel u_channel (
				.hclk          (hclk),
				.hresetn       (hresetn),
				.cfg           (chan_cfg[c]),
				.tb            (tb),
				.pin_in        (chan_pin_in[c]),
				.wr_en         (wr_value[c]),
				.wr_data       (hwdata[15:0]),
				.dbl_lower     (IS_LOWER && double_en[PAIR]),
				.dbl_upper     (IS_UPPER && double_en[PAIR]),
				.partner_match (IS_LOWER && chan_match[PARTNER]),
				.value         (chan_value[c]),
				.event_pulse   (chan_event[c]),
				.match         (chan_match[c]),
				.pin_out       (chan_pin_out[c]),
				.pin_oe        (chan_pin_oe[c])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------

	// event sources: one per channel plus both overflows
	always_comb
	begin
		stat_set                         = '0;
		stat_set[NUM_CHANNELS-1:0]       = chan_event;
		stat_set[STAT_OVF_A]             = ovf[0];
		stat_set[STAT_OVF_B]             = ovf[1];
	end

	// sticky status, write one to clear, a new event beats the clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			status <= '0;
		else if (wr_en && addr_q == OFS_STATUS)
			status <= (status & ~hwdata[STAT_W-1:0]) | stat_set;
		else
			status <= status | stat_set;
	end

	// level interrupt while any unmasked status bit is set
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= |(status & mask);
	end

endmodule : capture_compare_unit

/* File: rtl/capture_compare_pkg.sv */
package capture_compare_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 8;
	localparam int unsigned PHASE_UNIT_NS  = 4;   // one clock phase unit
	localparam int unsigned RESOLUTION_PU  = 16;  // finest timer step in phase units
	localparam int unsigned TICK_CYCLES    = (RESOLUTION_PU * PHASE_UNIT_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int unsigned PRESC_W        = 11;
	localparam int unsigned NUM_CHANNELS   = 12;
	localparam int unsigned NUM_PAIRS      = 4;
	localparam int unsigned STAT_W         = 14;
	localparam int unsigned STAT_OVF_A     = 12;
	localparam int unsigned STAT_OVF_B     = 13;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_CONTROL    = 12'h000;
	localparam logic [11:0] OFS_RELOAD_A   = 12'h004;
	localparam logic [11:0] OFS_RELOAD_B   = 12'h008;
	localparam logic [11:0] OFS_TIMER_A    = 12'h00C;
	localparam logic [11:0] OFS_TIMER_B    = 12'h010;
	localparam logic [11:0] OFS_STATUS     = 12'h014;
	localparam logic [11:0] OFS_MASK       = 12'h018;
	localparam logic [11:0] OFS_DOUBLE     = 12'h01C;
	localparam logic [11:0] OFS_PIN_STATE  = 12'h020;
	localparam logic [11:0] OFS_CHAN_VALUE = 12'h040;
	localparam logic [11:0] OFS_CHAN_CFG   = 12'h080;

	// control register fields
	localparam int unsigned CTL_RUN_A      = 0;
	localparam int unsigned CTL_RUN_B      = 1;
	localparam int unsigned CTL_PRESC_A    = 2;  // 3 bits
	localparam int unsigned CTL_EXT_A      = 5;
	localparam int unsigned CTL_PRESC_B    = 6;  // 3 bits
	localparam int unsigned CTL_W          = 9;

	// reset values and the counter top value
	localparam logic [15:0] RST_TIMER      = 16'h0000;
	localparam logic [15:0] RST_RELOAD     = 16'h0000;
	localparam logic [15:0] TIMER_TOP      = 16'hFFFF;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CH_OFF     = 3'b000,
		CH_CAPTURE = 3'b001,
		CH_CMP0    = 3'b010,
		CH_CMP1    = 3'b011,
		CH_CMP2    = 3'b100,
		CH_CMP3    = 3'b101
	} chan_mode_t;

	typedef enum logic [1:0] {
		EDGE_NONE = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_BOTH = 2'b11
	} edge_sel_t;

	typedef enum logic [1:0] {
		BUS_IDLE  = 2'b00,
		BUS_WRITE = 2'b01,
		BUS_READ  = 2'b10
	} bus_state_t;

	typedef struct packed {
		logic       use_b;
		edge_sel_t  edge_sel;
		chan_mode_t mode;
	} chan_cfg_t;

	typedef struct packed {
		logic [15:0] value_a;
		logic [15:0] value_b;
		logic        upd_a;
		logic        upd_b;
		logic        ovf_a;
		logic        ovf_b;
	} time_bus_t;

endpackage : capture_compare_pkg

/* File: rtl/capture_compare_channel.sv */
`timescale 1ns/1ps
module capture_compare_channel
	import capture_compare_pkg::*;
(
	input  wire logic                            hclk,
	input  wire logic                            hresetn,
	input  wire capture_compare_pkg::chan_cfg_t  cfg,
	input  wire capture_compare_pkg::time_bus_t  tb,
	input  wire logic                            pin_in,
	input  wire logic                            wr_en,
	input  wire logic [15:0]                     wr_data,
	input  wire logic                            dbl_lower,
	input  wire logic                            dbl_upper,
	input  wire logic                            partner_match,
	output logic [15:0]                          value,
	output logic                                 event_pulse,
	output logic                                 match,
	output logic                                 pin_out,
	output logic                                 pin_oe
);
	logic [15:0] sel_val;
	logic        sel_upd;
	logic        sel_ovf;
	logic        pin_prev;
	logic        trig;
	logic        is_cmp;
	logic        once;
	logic        done;

	// time base selection
	assign sel_val = cfg.use_b ? tb.value_b : tb.value_a;
	assign sel_upd = cfg.use_b ? tb.upd_b : tb.upd_a;
	assign sel_ovf = cfg.use_b ? tb.ovf_b : tb.ovf_a;

	// edge trigger on the channel pin
	assign trig = (cfg.mode == CH_CAPTURE) &&
		((cfg.edge_sel[0] && pin_in && !pin_prev) ||
		(cfg.edge_sel[1] && !pin_in && pin_prev));

	// compare hit, once-per-period modes suppressed after the first
	assign is_cmp = (cfg.mode == CH_CMP0) || (cfg.mode == CH_CMP1) ||
		(cfg.mode == CH_CMP2) || (cfg.mode == CH_CMP3);
	assign once   = (cfg.mode == CH_CMP2) || (cfg.mode == CH_CMP3);
	assign match  = is_cmp && sel_upd && (sel_val == value) &&
		!(once && done && !sel_ovf);

	// previous pin level for edge detection
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pin_prev <= 1'b0;
		else
			pin_prev <= pin_in;
	end

	// period flag: set by first hit, cleared by overflow of the assigned base
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			done <= 1'b0;
		else if (match && once)
			done <= 1'b1;
		else if (sel_ovf || !once)
			done <= 1'b0;
	end

	// channel register: capture beats a software write in the same cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			value <= RST_TIMER;
		else if (trig)
			value <= sel_val;
		else if (wr_en)
			value <= wr_data;
	end

	// interrupt request on capture or compare
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			event_pulse <= 1'b0;
		else
			event_pulse <= trig || match;
	end

	// pin drive
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
		end
		else
		begin
			pin_oe <= !dbl_upper && (dbl_lower || cfg.mode == CH_CMP1 ||
				cfg.mode == CH_CMP3);
			if (dbl_upper)
				pin_out <= pin_out;  // pin belongs to the lower partner
			else if (dbl_lower)
			begin
				if (match ^ partner_match)
					pin_out <= !pin_out;
			end
			else if (cfg.mode == CH_CMP1 && match)
				pin_out <= !pin_out;
			else if (cfg.mode == CH_CMP3 && match)
				pin_out <= 1'b1;
			else if (cfg.mode == CH_CMP3 && sel_ovf)
				pin_out <= 1'b0;
		end
	end

endmodule : capture_compare_channel

/* File: verification/ext_pins.sv */
`timescale 1ns/1ps
module ext_pins
	import capture_compare_pkg::*;
(
	input  wire logic                                          hclk,
	input  wire logic [capture_compare_pkg::NUM_CHANNELS-1:0]  pin_out,
	input  wire logic [capture_compare_pkg::NUM_CHANNELS-1:0]  pin_oe,
	output logic [capture_compare_pkg::NUM_CHANNELS-1:0]       pin_in,
	output logic                                               count_pin
);
	logic [NUM_CHANNELS-1:0] ext = '0;

	// wire level: the channel wins where it drives, the outside source elsewhere
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
	initial count_pin = 1'b0;

	// one count pulse, four cycles low then four high
	task automatic pulse();
		repeat (4) @(posedge hclk);
		count_pin <= 1'b1;
		repeat (4) @(posedge hclk);
		count_pin <= 1'b0;
	endtask : pulse

	// outside level of one channel pin
	task automatic set(input int i, input logic lvl);
		@(posedge hclk);
		ext[i] <= lvl;
	endtask : set
endmodule : ext_pins

/* File: verification/capture_compare_unit_monitor.sv */
`timescale 1ns/1ps
module capture_compare_unit_monitor
	import capture_compare_pkg::*;
(
	input wire logic                                          hclk,
	input wire logic                                          hresetn,
	input wire logic                                          hsel,
	input wire logic [31:0]                                   haddr,
	input wire logic [1:0]                                    htrans,
	input wire logic                                          hwrite,
	input wire logic [31:0]                                   hwdata,
	input wire logic                                          hready,
	input wire logic                                          hreadyout,
	input wire logic                                          hresp,
	input wire logic [31:0]                                   hrdata,
	input wire logic                                          irq,
	input wire logic [capture_compare_pkg::NUM_CHANNELS-1:0]  chan_pin_out,
	input wire logic [capture_compare_pkg::NUM_CHANNELS-1:0]  chan_pin_oe
);
	logic        wt;
	logic        rt;
	logic        mask_pend;
	logic [13:0] mask_q;

	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// address phases taken
	assign wt = hsel && htrans[1] && hready && hwrite;
	assign rt = hsel && htrans[1] && hready && !hwrite;

	// shadow of the interrupt mask
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mask_pend <= 1'b0;
			mask_q    <= 14'h0;
		end
		else
		begin
			mask_pend <= wt && haddr[11:0] == OFS_MASK;
			if (mask_pend)
				mask_q <= hwdata[13:0];
		end
	end

	a_read_wait: assert property (rt |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (wt |=> hreadyout)
		else $error("write stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_rdata_hold: assert property ($changed(hrdata) |-> $rose(hreadyout))
		else $error("read data moved outside a read");
	a_irq_clear: assert property ($fell(irq) |-> $past(wt, 2) || $past(wt, 3))
		else $error("interrupt dropped without a write");
	a_mask_quiet: assert property (mask_q == 14'h0 && $past(mask_q) == 14'h0 |-> !irq)
		else $error("interrupt with all sources masked");
	a_oe_change: assert property ($changed(chan_pin_oe) |-> $past(wt) || $past(wt, 2) || $past(wt, 3))
		else $error("pin drive changed without configuration");
	a_pin_hold: assert property (((chan_pin_out ^ $past(chan_pin_out)) & ~chan_pin_oe & ~$past(chan_pin_oe)) == '0)
		else $error("undriven pin level moved");
	a_toggle_gap: assert property ($changed(chan_pin_out) && $stable(chan_pin_oe) |=> $stable(chan_pin_out) [*5])
		else $error("pin events closer than one timer step");
endmodule : capture_compare_unit_monitor

bind capture_compare_unit capture_compare_unit_monitor i_mon (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .irq(irq), .chan_pin_out(chan_pin_out),
	.chan_pin_oe(chan_pin_oe)
);

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
	import capture_compare_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        hready;
	logic        hresp;
	logic [31:0] hrdata, d;
	logic        irq, cnt_pin, b;
	logic [11:0] pin_in, pin_out, pin_oe;
	logic [15:0] v, r, t, cap;
	int          n_fail = 0;
	int          checks = 0;
	int          ch, n;
	logic [2:0]  p;
	chan_mode_t  imode [2] = '{CH_CMP0, CH_CMP2};

	capture_compare_unit i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .irq(irq),
		.time_base_a_count_pin(cnt_pin), .chan_pin_in(pin_in), .chan_pin_out(pin_out),
		.chan_pin_oe(pin_oe));
	ext_pins i_ext (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
		.count_pin(cnt_pin));

	initial
		forever #4 hclk = ~hclk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	// one single-word transfer; read data lands in d
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge hclk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 20'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
		do @(posedge hclk); while (hready !== 1'b1);
		d = hrdata;
	endtask : bus

	function automatic logic [31:0] cfg(input chan_mode_t m, input edge_sel_t e, input logic s);
		return {26'h0, s, e, m};
	endfunction : cfg

	function automatic logic [11:0] ca(input int i, input logic [11:0] base);
		return base + 12'(4 * i);
	endfunction : ca

	function automatic logic hit(input edge_sel_t e, input logic lvl);
		return lvl ? e[0] : e[1];
	endfunction : hit

	// load a time base and start it with a random prescaler
	task automatic go(input logic s, input logic [15:0] tv);
		bus(1'b1, s ? OFS_TIMER_B : OFS_TIMER_A, {16'h0, tv});
		p = 3'($urandom_range(3));
		bus(1'b1, OFS_CONTROL, {23'h0, p, 1'b0, p, s, !s});
	endtask : go

	task automatic wait_pin(input int i, input logic lvl);
		int k = 0;
		while (pin_out[i] !== lvl && k < 3000)
		begin
			@(posedge hclk);
			k++;
		end
		chk({31'h0, pin_out[i]}, {31'h0, lvl});
	endtask : wait_pin

	// read status and interrupt, clear, then both must be quiet
	task automatic stat(input logic [31:0] exp);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(d, exp);
		chk({31'h0, irq}, {31'h0, exp != 0});
		bus(1'b1, OFS_STATUS, 32'h3FFF);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(d, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask : stat

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h57D1));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		// reset status, a reload word and an unmapped word
		bus(1'b1, 12'h3FC, 32'hFFFF_FFFF);
		foreach (imode[j])
		begin
			bus(1'b0, j ? 12'h3FC : OFS_STATUS, 32'h0);
			chk(d, 32'h0);
		end
		r = 16'($urandom);
		bus(1'b1, OFS_RELOAD_B, {16'hFFFF, r});
		bus(1'b0, OFS_RELOAD_B, 32'h0);
		chk(d, {16'h0, r});
		bus(1'b1, OFS_RELOAD_B, 32'h0);
		bus(1'b1, OFS_MASK, 32'h3FFF);
		// toggle compare, matched twice, then the interrupt checked quiet while masked
		ch = $urandom_range(11);
		b = 1'($urandom_range(1));
		v = 16'($urandom_range(16'hFF00, 16'h0010));
		bus(1'b1, ca(ch, OFS_CHAN_VALUE), {16'h0, v});
		bus(1'b1, ca(ch, OFS_CHAN_CFG), cfg(CH_CMP1, EDGE_NONE, b));
		for (int k = 0; k < 2; k++)
		begin
			go(b, v - 16'h2);
			wait_pin(ch, !k[0]);
			chk({31'h0, pin_oe[ch]}, 32'h1);
			bus(1'b1, OFS_CONTROL, 32'h0);
		end
		bus(1'b1, OFS_MASK, 32'h0);
		bus(1'b0, OFS_MASK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, OFS_MASK, 32'h3FFF);
		stat(32'(1) << ch);
		bus(1'b1, ca(ch, OFS_CHAN_CFG), 32'h0);
		// interrupt-only compares, rewound inside one period
		foreach (imode[j])
		begin
			ch = $urandom_range(11);
			v = 16'($urandom_range(16'hFF00, 16'h0010));
			bus(1'b1, ca(ch, OFS_CHAN_VALUE), {16'h0, v});
			bus(1'b1, ca(ch, OFS_CHAN_CFG), cfg(imode[j], EDGE_NONE, 1'b0));
			for (int k = 0; k < 2; k++)
			begin
				go(1'b0, v - 16'h2);
				repeat (40 << p) @(posedge hclk);
				bus(1'b1, OFS_CONTROL, 32'h0);
				chk({31'h0, pin_oe[ch]}, 32'h0);
				stat((k == 0 || imode[j] == CH_CMP0) ? 32'(1) << ch : 32'h0);
			end
			bus(1'b1, ca(ch, OFS_CHAN_CFG), 32'h0);
		end
		// capture on rising, falling and both edges, either time base
		ch = $urandom_range(11);
		b = 1'($urandom_range(1));
		cap = 16'h0;
		bus(1'b1, ca(ch, OFS_CHAN_VALUE), 32'h0);
		for (int e = 1; e < 4; e++)
		begin
			bus(1'b1, ca(ch, OFS_CHAN_CFG), cfg(CH_CAPTURE, edge_sel_t'(e), b));
			for (int l = 1; l >= 0; l--)
			begin
				t = 16'($urandom);
				bus(1'b1, b ? OFS_TIMER_B : OFS_TIMER_A, {16'h0, t});
				i_ext.set(ch, l[0]);
				repeat (4) @(posedge hclk);
				if (hit(edge_sel_t'(e), l[0]))
					cap = t;
				bus(1'b0, ca(ch, OFS_CHAN_VALUE), 32'h0);
				chk(d, {16'h0, cap});
				stat(hit(edge_sel_t'(e), l[0]) ? 32'(1) << ch : 32'h0);
			end
		end
		bus(1'b1, ca(ch, OFS_CHAN_CFG), 32'h0);
		// time base a counting pulses on its count pin
		n = $urandom_range(10, 3);
		bus(1'b1, OFS_TIMER_A, 32'h0);
		bus(1'b1, OFS_CONTROL, 32'h0000_0021);
		repeat (n) i_ext.pulse();
		bus(1'b1, OFS_CONTROL, 32'h0);
		bus(1'b0, OFS_TIMER_A, 32'h0);
		chk(d, 32'(n));
		// set on match, cleared by the overflow that reloads the base
		ch = $urandom_range(11);
		b = 1'($urandom_range(1));
		r = 16'($urandom_range(16'h00FF));
		bus(1'b1, b ? OFS_RELOAD_B : OFS_RELOAD_A, {16'h0, r});
		bus(1'b1, ca(ch, OFS_CHAN_VALUE), 32'h0000_FFFE);
		bus(1'b1, ca(ch, OFS_CHAN_CFG), cfg(CH_CMP3, EDGE_NONE, b));
		go(b, 16'hFFFC);
		wait_pin(ch, 1'b1);
		wait_pin(ch, 1'b0);
		bus(1'b1, OFS_CONTROL, 32'h0);
		bus(1'b0, b ? OFS_TIMER_B : OFS_TIMER_A, 32'h0);
		chk(d, {16'h0, r});
		stat((32'(1) << ch) | (32'(1) << (STAT_OVF_A + 32'(b))));
		bus(1'b1, ca(ch, OFS_CHAN_CFG), 32'h0);
		// paired registers toggle the lower pin only
		ch = $urandom_range(3);
		v = 16'($urandom_range(16'hFF00, 16'h0010));
		for (int k = 0; k < 2; k++)
		begin
			bus(1'b1, ca(ch + 4 * k, OFS_CHAN_VALUE), {16'h0, v + 16'(3 * k)});
			bus(1'b1, ca(ch + 4 * k, OFS_CHAN_CFG), cfg(CH_CMP1, EDGE_NONE, 1'b0));
		end
		bus(1'b1, OFS_DOUBLE, 32'(1) << ch);
		go(1'b0, v - 16'h1);
		wait_pin(ch, 1'b1);
		chk({31'h0, pin_oe[ch + 4]}, 32'h0);
		bus(1'b0, OFS_PIN_STATE, 32'h0);
		chk(d, 32'(1) << ch);
		wait_pin(ch, 1'b0);
		bus(1'b1, OFS_CONTROL, 32'h0);
		stat((32'(1) << ch) | (32'(1) << (ch + 4)));
		conclude();
	end

	// watchdog
	initial
	begin
		repeat (60000) @(posedge hclk);
		n_fail++;
		conclude();
	end
endmodule : tb
